//--- bench/twm_host_ctrl_tb.sv
// Self-checking bench for the two-wire bus host controller.
`timescale 1ns/1ps
`default_nettype none

module twm_host_ctrl_tb;
  typedef struct {logic [31:0] v; logic [31:0] m; logic s;} twm_exp_t;
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic        tb_sda_oe = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [7:0]  stretch   = 8'h00;
  logic [7:0]  tx_base   = 8'h00;
  logic [31:0] pwdata    = 32'h00000000;
  logic [31:0] seed      = 32'h00015906;
  logic [31:0] prdata, rv;
  logic        pready, pslverr, c_oe, d_oe, scl, sda, m_scl_oe, m_sda_oe, rec_stb;
  logic        c_o, d_o;
  logic [8:0]  rec;
  twm_exp_t    e;
  twm_exp_t    q_rd[$];
  logic [8:0]  q_bus[$];
  int          err_total  = 0;
  int          n_compared = 0;

  // Open-drain wires, pulled up when nobody pulls low
  assign scl = !(c_oe || m_scl_oe);
  assign sda = !(d_oe || m_sda_oe || tb_sda_oe);
  initial forever #5 ref_clk = ~ref_clk;

  twm_host_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port0_serial_clock_i(scl), .port0_serial_clock_o(c_o),
    .port0_serial_clock_oe(c_oe), .port0_serial_line_i(sda), .port0_serial_line_o(d_o),
    .port0_serial_line_oe(d_oe));
  twm_slave_model u_slave (.ref_clk(ref_clk), .scl(scl), .sda(sda), .stretch(stretch),
    .tx_base(tx_base), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .rec_stb(rec_stb), .rec(rec));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] twm_lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] v, logic [31:0] m, logic s);
    q_rd.push_back('{v, m, s});
    apb(1'b0, a, 32'h00000000, rv);
  endtask
  task automatic wait_lvl(logic c, logic d);
    int n;
    for (n = 0; n < 3000 && !(scl === c && sda === d); n++) @(posedge ref_clk);
    if (n == 3000) check("bus level wait", 32'h00000001, 32'h00000000);
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(twm_pkg::OFS_CTRL, 32'h00000000, 32'h00000000, 1'b0);
      if (rv[twm_pkg::STS_BUSY] === 1'b0) break;
    end
    if (n == 3000) check("busy wait", 32'h00000001, 32'h00000000);
  endtask
  task automatic xfer(logic [7:0] t, logic [7:0] b, logic [31:0] c);
    wr(twm_pkg::OFS_TARGET, {24'h000000, t});
    wr(twm_pkg::OFS_BYTE, {24'h000000, b});
    wr(twm_pkg::OFS_CTRL, c);
    wait_done();
  endtask
  task automatic complete_run();
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && q_rd.size() > 0) begin
      e = q_rd.pop_front();
      if (e.m != 32'h00000000) begin
        check("read data", prdata & e.m, e.v);
        check("slave error", {31'h0, pslverr}, {31'h0, e.s});
      end
    end
    if (rec_stb && q_bus.size() == 0) check("bus unit count", 32'h1, 32'h0);
    else if (rec_stb) check("bus unit", {23'h0, rec}, {23'h0, q_bus.pop_front()});
  end
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(twm_pkg::OFS_DIV, {16'h0000, twm_pkg::DIV_RESET}, 32'hFFFFFFFF, 1'b0);
    rd(twm_pkg::OFS_CTRL, 32'h00000000, 32'h0000001F, 1'b0);
    rd(8'h10, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    wr(twm_pkg::OFS_DIV, 32'h00000001);
    seed = twm_lfsr(twm_lfsr(seed));
    q_bus.push_back({8'h76, 1'b0});
    q_bus.push_back({seed[7:0], 1'b0});
    xfer(8'h76, seed[7:0], 32'h00000037);
    rd(twm_pkg::OFS_CTRL, 32'h00000010, 32'h0000001F, 1'b0);
    rd(twm_pkg::OFS_CTRL, 32'h000001E0, 32'h000001E0, 1'b0);
    check("driven levels", {30'h0, c_o, d_o}, 32'h0);
    stretch <= 8'h40;
    tx_base <= seed[15:8];
    q_bus.push_back({8'h77, 1'b0});
    q_bus.push_back({seed[15:8], 1'b0});
    xfer(8'h77, 8'h00, 32'h0000000B);
    rd(twm_pkg::OFS_CTRL, 32'h00000008, 32'h00000008, 1'b0);
    q_bus.push_back({seed[15:8] + 8'h01, 1'b1});
    wr(twm_pkg::OFS_CTRL, 32'h00000005);
    wait_done();
    rd(twm_pkg::OFS_BYTE, {24'h0, seed[15:8] + 8'h01}, 32'h000000FF, 1'b0);
    stretch <= 8'h00;
    q_bus.push_back({8'h76, 1'b0});
    q_bus.push_back({seed[23:16], 1'b0});
    xfer(8'h76, seed[23:16], 32'h00000003);
    q_bus.push_back({8'h77, 1'b0});
    q_bus.push_back({seed[15:8], 1'b1});
    xfer(8'h77, 8'h00, 32'h00000007);
    rd(twm_pkg::OFS_CTRL, 32'h00000010, 32'h0000001F, 1'b0);
    q_bus.push_back({8'h40, 1'b1});
    xfer(8'h40, 8'h00, 32'h00000007);
    rd(twm_pkg::OFS_CTRL, 32'h00000072, 32'h000001FF, 1'b0);
    tb_sda_oe <= 1'b1;
    wr(twm_pkg::OFS_CTRL, 32'h00000007);
    repeat (100) @(posedge ref_clk);
    check("clock pull", {31'h0, c_oe}, 32'h0);
    check("data pull", {31'h0, d_oe}, 32'h0);
    q_bus.push_back({8'h40, 1'b1});
    tb_sda_oe <= 1'b0;
    wait_done();
    wr(twm_pkg::OFS_TARGET, 32'h00000076);
    wr(twm_pkg::OFS_CTRL, 32'h00000007);
    wait_lvl(1'b1, 1'b0);
    wait_lvl(1'b0, 1'b0);
    tb_sda_oe <= 1'b1;
    wait_done();
    rd(twm_pkg::OFS_CTRL, 32'h00000014, 32'h00000017, 1'b0);
    check("lost data pull", {31'h0, d_oe}, 32'h0);
    tb_sda_oe <= 1'b0;
    repeat (50) @(posedge ref_clk);
    check("bus queue left", 32'(q_bus.size()), 32'h0);
    complete_run();
  end
endmodule

`default_nettype wire

//--- bench/twm_slave_model.sv
// Behavioural slave device standing on the two-wire bus.
`timescale 1ns/1ps
`default_nettype none

module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h3B
) (
  input  wire logic       ref_clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] stretch,
  input  wire logic [7:0] tx_base,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic            rec_stb,
  output logic [8:0]      rec
);
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  logic       adr   = 1'b0;
  logic       act   = 1'b0;
  logic       rd    = 1'b0;
  logic       snd   = 1'b0;
  logic       mack  = 1'b0;
  logic       bnd   = 1'b0;
  logic [3:0] cnt   = 4'h0;
  logic [7:0] sh    = 8'h00;
  logic [7:0] tx    = 8'h00;
  logic [7:0] idx   = 8'h00;
  logic [7:0] st    = 8'h00;
  logic [7:0] nxt;
  logic       go;

  // Read data walks up from the base the bench gives
  assign nxt = tx_base + idx;
  assign go  = act && rd && mack;
  initial begin
    scl_oe  = 1'b0;
    sda_oe  = 1'b0;
    rec_stb = 1'b0;
    rec     = 9'h000;
  end

  always @(posedge ref_clk) begin
    scl_q   <= scl;
    sda_q   <= sda;
    rec_stb <= 1'b0;
    scl_oe  <= (st != 8'h00);
    if (st != 8'h00) st <= st - 8'h01;
    if (scl && scl_q && sda_q && !sda) begin
      cnt    <= 4'h0;
      adr    <= 1'b1;
      act    <= 1'b0;
      snd    <= 1'b0;
      bnd    <= 1'b0;
      idx    <= 8'h00;
      sda_oe <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      act    <= 1'b0;
      snd    <= 1'b0;
      bnd    <= 1'b0;
      cnt    <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl && !scl_q) begin
      sh <= {sh[6:0], sda};
      if (cnt == 4'h8) begin
        rec     <= {sh, sda};
        rec_stb <= 1'b1;
        mack    <= !sda;
        bnd     <= 1'b1;
        cnt     <= 4'h0;
      end else cnt <= cnt + 4'h1;
    end else if (!scl && scl_q) begin
      // Data only moves after a clock fall
      if (bnd) begin
        bnd    <= 1'b0;
        st     <= stretch;
        snd    <= go;
        tx     <= nxt;
        idx    <= idx + 8'(go);
        sda_oe <= go && !nxt[7];
      end else if (cnt == 4'h8) begin
        adr    <= 1'b0;
        act    <= adr ? (sh[7:1] == ADDR) : act;
        rd     <= adr ? sh[0] : rd;
        sda_oe <= adr ? (sh[7:1] == ADDR) : (act && !rd);
      end else if (snd && cnt != 4'h0) sda_oe <= !tx[7 - cnt];
    end
  end
endmodule

`default_nettype wire

//--- src/twm_host_ctrl.sv
// Two-wire bus master that drives the device's bus pins, with APB registers.
//
// How it works
// R1: Bus counts as idle only while data and clock lines both read high.
// R2: A byte is eight data clocks plus one acknowledge clock.
// R3: Bytes go out most significant bit first.
// R4: While a receiver holds the clock low, the master waits before going on.
// R5: Start is data falling with clock high; stop is data rising with clock high.
// R6: Device tracks bus busy from start until stop.
// R7: Stop bit chooses stop after the byte, or holding for a repeated start.
// R8: Software writes address with direction, then control with stop, start, run.
// R9: Device sets its done status flag and shows received data when done.
// R10: Device acks received bytes when its ack control bit is set.
// R11: Device slave flags start and stop in raw and masked status.
// R12: First byte after start is seven address bits and a direction bit.
// R13: Transfers end with stop, or repeated start may address another slave.
// R14: Data changes only while clock is low, stable while high.
// R15: Master clocks the ack bit; the transmitter releases data during it.
// R16: Receiver acks by pulling data low during the ack clock pulse.
// R17: An unacknowledged address leaves data high; master stops and aborts.
// R18: Master receiver acks each byte but the last, then issues stop.
// R19: Master begins only on an idle bus.
// R20: A master losing arbitration releases data and waits for idle bus.
// R21: Arbitration runs over address bits, then through data bits.
// R22: Bus runs at standard or fast rate chosen by software.
// R23: Device derives its clock from a timer setting, low six, high four units.
// R24: Lines are only pulled low or released; actual levels are sampled.
`timescale 1ns/1ps
`default_nettype none

module twm_host_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port0_serial_clock_i,
  output logic             port0_serial_clock_o,
  output logic             port0_serial_clock_oe,
  input  wire logic        port0_serial_line_i,
  output logic             port0_serial_line_o,
  output logic             port0_serial_line_oe
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0]  master_target_address_reg;
  logic [7:0]  tx_byte;
  logic [7:0]  master_byte_reg;
  logic [15:0] clock_divider_setting;
  logic [3:0]  cmd;
  logic        cmd_pend;
  logic        err;
  logic        arb_lost;
  logic        done;
  logic        bus_busy;
  logic [1:0]  slave_raw_event_status;
  logic [1:0]  ev_mask;
  twm_pkg::twm_state_t st;
  logic [16:0] div_cnt;
  logic [3:0]  ph;
  logic [3:0]  bitn;
  logic [7:0]  sh;
  logic        is_addr;
  logic        rx;
  logic        scl_m;
  logic        scl_s;
  logic        scl_p;
  logic        sda_m;
  logic        sda_s;
  logic        sda_p;

  // ----------------------------------------------------------------
  // Pin synchronisers and bus condition detect
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_p} <= {port0_serial_clock_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {port0_serial_line_i, sda_m, sda_s};
    end
  end

  wire start_seen = scl_s && scl_p && sda_p && !sda_s;  // R5
  wire stop_seen  = scl_s && scl_p && !sda_p && sda_s;  // R5
  wire bus_free   = !bus_busy && scl_s && sda_s;        // R1

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;  // R6
    end else if (stop_seen) begin
      bus_busy <= 1'b0;  // R6
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  wire sel_tgt  = paddr == twm_pkg::OFS_TARGET;
  wire sel_byte = paddr == twm_pkg::OFS_BYTE;
  wire sel_ctrl = paddr == twm_pkg::OFS_CTRL;
  wire sel_div  = paddr == twm_pkg::OFS_DIV;
  wire mapped   = sel_tgt | sel_byte | sel_ctrl | sel_div;
  wire wr_en    = psel && penable && pwrite && mapped;
  wire moving   = !(st == twm_pkg::ST_IDLE || st == twm_pkg::ST_HOLD);
  wire busy     = cmd_pend || moving;
  // Commands arriving while busy are dropped rather than queued
  wire cmd_wr   = wr_en && sel_ctrl && pwdata[twm_pkg::CTL_RUN] && !busy;
  // A new command clears the events; one seen in the same cycle survives
  wire [1:0]  ev_keep = cmd_wr ? 2'b00 : slave_raw_event_status;
  wire [1:0]  slave_masked_event_status = slave_raw_event_status & ev_mask;  // R11
  wire [31:0] status = {23'h0, slave_masked_event_status, slave_raw_event_status,
                        done, bus_busy, arb_lost, err, busy};

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = sel_tgt  ? {24'h0, master_target_address_reg} :
                   sel_byte ? {24'h0, master_byte_reg} :
                   sel_ctrl ? status :
                   sel_div  ? {16'h0, clock_divider_setting} : 32'h0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      master_target_address_reg <= 8'h00;
      tx_byte                   <= 8'h00;
      clock_divider_setting     <= twm_pkg::DIV_RESET;
      ev_mask                   <= 2'b00;
      slave_raw_event_status    <= 2'b00;
    end else begin
      slave_raw_event_status <= ev_keep | {stop_seen, start_seen};  // R11
      if (wr_en && sel_tgt) master_target_address_reg <= pwdata[7:0];
      if (wr_en && sel_byte) tx_byte <= pwdata[7:0];
      if (wr_en && sel_div) clock_divider_setting <= pwdata[15:0];  // R22
      if (wr_en && sel_ctrl) ev_mask <= pwdata[twm_pkg::CTL_EVM +: 2];  // R11
    end
  end

  // ----------------------------------------------------------------
  // Bus rate divider: one tick per 2 x (setting + 1) reference cycles
  // ----------------------------------------------------------------
  wire tick = div_cnt >= {clock_divider_setting, 1'b1};  // R23

  always_ff @(posedge ref_clk) begin
    if (!rst_n || tick) begin
      div_cnt <= 17'h00000;
    end else begin
      div_cnt <= div_cnt + 17'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  wire high_ph  = st == twm_pkg::ST_BIT_HIGH || st == twm_pkg::ST_RS_HIGH ||
                  st == twm_pkg::ST_STOP_HIGH;
  wire low_end  = tick && ph == twm_pkg::clock_low_phase_units - 4'h1;  // R23
  wire high_end = tick && ph == twm_pkg::clock_high_phase_units - 4'h1 && scl_s;  // R23
  wire samp     = tick && ph == twm_pkg::SAMPLE_UNIT && scl_s;
  wire ack_bit  = bitn == twm_pkg::ACK_BIT;
  wire drv_one  = !rx && !ack_bit && sh[7];
  wire lost     = st == twm_pkg::ST_BIT_HIGH && samp && drv_one && !sda_s;
  wire nack     = sh[0];

  // Level to pull the data line for the current bit
  function automatic logic pull_sda(input logic r, input logic a, input logic b7,
                                    input logic ack_en);
    pull_sda = a ? (r & ack_en) : (!r & !b7);
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st                    <= twm_pkg::ST_IDLE;
      ph                    <= 4'h0;
      bitn                  <= 4'h0;
      sh                    <= 8'h00;
      is_addr               <= 1'b0;
      rx                    <= 1'b0;
      cmd                   <= 4'h0;
      cmd_pend              <= 1'b0;
      err                   <= 1'b0;
      arb_lost              <= 1'b0;
      done                  <= 1'b0;
      master_byte_reg       <= 8'h00;
      port0_serial_clock_oe <= 1'b0;
      port0_serial_line_oe  <= 1'b0;
    end else begin
      if (cmd_wr) begin
        cmd      <= pwdata[3:0];  // R8
        cmd_pend <= 1'b1;
        err      <= 1'b0;
        arb_lost <= 1'b0;
        done     <= 1'b0;
      end
      if (tick) ph <= ph + 4'h1;
      if (high_ph && !scl_s) ph <= 4'h0;  // R4
      if (lost) begin
        // Off the bus at once; a new start must wait for a stop
        st                    <= twm_pkg::ST_IDLE;  // R20 R21
        port0_serial_line_oe  <= 1'b0;  // R20
        port0_serial_clock_oe <= 1'b0;
        arb_lost              <= 1'b1;
        done                  <= 1'b1;
      end else begin
        unique case (st)
          twm_pkg::ST_IDLE: begin
            if (cmd_pend && cmd[twm_pkg::CTL_START] && bus_free) begin  // R19
              st                   <= twm_pkg::ST_START;
              ph                   <= 4'h0;
              port0_serial_line_oe <= 1'b1;  // R5
            end else if (cmd_pend && !cmd[twm_pkg::CTL_START]) begin
              cmd_pend <= 1'b0;
              err      <= 1'b1;
              done     <= 1'b1;
            end
          end
          twm_pkg::ST_START: begin
            if (tick && ph == twm_pkg::clock_high_phase_units) begin
              st                    <= twm_pkg::ST_BIT_LOW;
              ph                    <= 4'h0;
              bitn                  <= 4'h0;
              sh                    <= master_target_address_reg;  // R12
              is_addr               <= 1'b1;
              rx                    <= 1'b0;
              cmd_pend              <= 1'b0;
              port0_serial_clock_oe <= 1'b1;
            end
          end
          twm_pkg::ST_HOLD: begin
            if (cmd_pend && cmd[twm_pkg::CTL_START]) begin
              st       <= twm_pkg::ST_RS_LOW;  // R13
              ph       <= 4'h0;
            end else if (cmd_pend) begin
              st       <= twm_pkg::ST_BIT_LOW;
              ph       <= 4'h0;
              bitn     <= 4'h0;
              sh       <= tx_byte;
              is_addr  <= 1'b0;
              cmd_pend <= 1'b0;
            end
          end
          twm_pkg::ST_RS_LOW: begin
            if (ph == 4'h1) port0_serial_line_oe <= 1'b0;  // R14
            if (low_end) begin
              st                    <= twm_pkg::ST_RS_HIGH;
              ph                    <= 4'h0;
              port0_serial_clock_oe <= 1'b0;
            end
          end
          twm_pkg::ST_RS_HIGH: begin
            if (high_end) begin
              st                   <= twm_pkg::ST_START;  // R5
              ph                   <= 4'h0;
              port0_serial_line_oe <= 1'b1;
            end
          end
          twm_pkg::ST_BIT_LOW: begin
            if (ph == 4'h1) begin
              // Data moves only a tick after the clock fell
              port0_serial_line_oe <= pull_sda(rx, ack_bit, sh[7],
                                               cmd[twm_pkg::CTL_ACK]);  // R3 R10 R14 R15 R16
            end
            if (low_end) begin
              st                    <= twm_pkg::ST_BIT_HIGH;
              ph                    <= 4'h0;
              port0_serial_clock_oe <= 1'b0;
            end
          end
          twm_pkg::ST_BIT_HIGH: begin
            // A received byte must survive its own ack bit
            if (samp && !(ack_bit && rx)) sh <= {sh[6:0], sda_s};  // R3 R24
            if (high_end) begin
              ph                    <= 4'h0;
              port0_serial_clock_oe <= 1'b1;
              if (!ack_bit) begin
                st   <= twm_pkg::ST_BIT_LOW;
                bitn <= bitn + 4'h1;  // R2
              end else if (is_addr && nack) begin
                st  <= twm_pkg::ST_STOP_LOW;  // R17
                err <= 1'b1;
              end else if (is_addr) begin
                st      <= twm_pkg::ST_BIT_LOW;
                bitn    <= 4'h0;
                sh      <= tx_byte;
                is_addr <= 1'b0;
                rx      <= master_target_address_reg[0];  // R12
              end else begin
                if (rx) master_byte_reg <= sh;  // R9
                if (!rx && nack) err <= 1'b1;
                if ((!rx && nack) || cmd[twm_pkg::CTL_STOP]) begin
                  st <= twm_pkg::ST_STOP_LOW;  // R7 R18
                end else begin
                  st   <= twm_pkg::ST_HOLD;  // R7
                  done <= 1'b1;
                end
              end
            end
          end
          twm_pkg::ST_STOP_LOW: begin
            if (ph == 4'h1) port0_serial_line_oe <= 1'b1;  // R14
            if (low_end) begin
              st                    <= twm_pkg::ST_STOP_HIGH;
              ph                    <= 4'h0;
              port0_serial_clock_oe <= 1'b0;
            end
          end
          twm_pkg::ST_STOP_HIGH: begin
            if (high_end) begin
              st                   <= twm_pkg::ST_STOP_END;
              ph                   <= 4'h0;
              port0_serial_line_oe <= 1'b0;  // R5
            end
          end
          twm_pkg::ST_STOP_END: begin
            if (tick && ph == twm_pkg::clock_high_phase_units) begin
              st   <= twm_pkg::ST_IDLE;  // R13
              done <= 1'b1;  // R9
            end
          end
        endcase
      end
    end
  end

  // Open drain: the driven level is always low
  assign port0_serial_clock_o = 1'b0;  // R24
  assign port0_serial_line_o  = 1'b0;  // R24

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  data_stable_a: assert property (st == twm_pkg::ST_BIT_HIGH && $past(st) == st
    |-> $stable(port0_serial_line_oe)) else $error("data moved in clock high");  // R14
  ack_release_a: assert property (st == twm_pkg::ST_BIT_HIGH && ack_bit && !rx
    |-> !port0_serial_line_oe) else $error("transmitter held data in ack");  // R15
  msb_first_a: assert property (st == twm_pkg::ST_BIT_HIGH && !rx && !ack_bit && ph == 4'h0
    |-> port0_serial_line_oe == !sh[7]) else $error("bit order wrong");  // R3
  rx_ack_a: assert property (st == twm_pkg::ST_BIT_HIGH && rx && ack_bit
    |-> port0_serial_line_oe == cmd[twm_pkg::CTL_ACK]) else $error("ack level wrong");  // R16
  idle_start_a: assert property (st == twm_pkg::ST_IDLE ##1 st == twm_pkg::ST_START
    |-> $past(bus_free)) else $error("start on busy bus");  // R19
  stretch_wait_a: assert property (st == twm_pkg::ST_BIT_HIGH && !scl_s && !lost
    |=> st == twm_pkg::ST_BIT_HIGH && !port0_serial_clock_oe) else $error("no stretch wait");  // R4
  arb_release_a: assert property ($rose(arb_lost)
    |-> !port0_serial_line_oe && !port0_serial_clock_oe && st == twm_pkg::ST_IDLE)
    else $error("lost master kept driving");  // R20
  nack_stop_a: assert property ($rose(err) && $past(st) == twm_pkg::ST_BIT_HIGH
    |-> st == twm_pkg::ST_STOP_LOW) else $error("no stop after nack");  // R17
  start_cond_a: assert property (st == twm_pkg::ST_START
    |-> !port0_serial_clock_oe) else $error("start with clock low");  // R5

endmodule

`default_nettype wire

//--- src/twm_pkg.sv
// Constants and types for the two-wire bus host controller.
package twm_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TARGET = 8'h00;
  localparam logic [7:0] OFS_BYTE   = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam logic [7:0] OFS_DIV    = 8'h0C;

  // ----------------------------------------------------------------
  // Control and status bit positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN   = 0;
  localparam int CTL_START = 1;
  localparam int CTL_STOP  = 2;
  localparam int CTL_ACK   = 3;
  localparam int CTL_EVM   = 4;
  localparam int STS_BUSY  = 0;
  localparam int STS_ERR   = 1;
  localparam int STS_ARB   = 2;
  localparam int STS_BUSB  = 3;
  localparam int STS_DONE  = 4;
  localparam int STS_RAW   = 5;
  localparam int STS_MSK   = 7;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_RESET = 16'h0009;
  localparam logic [3:0]  clock_low_phase_units  = 4'h6;
  localparam logic [3:0]  clock_high_phase_units = 4'h4;
  localparam logic [3:0]  SAMPLE_UNIT = 4'h2;
  localparam logic [3:0]  ACK_BIT     = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_RS_LOW, ST_RS_HIGH, ST_BIT_LOW, ST_BIT_HIGH,
    ST_STOP_LOW, ST_STOP_HIGH, ST_STOP_END, ST_HOLD
  } twm_state_t;

endpackage
